// File: rtl/pmbst_pkg.sv
// Shared command codes, field layouts and reset values of the register bank.
package pmbst_pkg;
    // Command codes.
    localparam logic [7:0] CODE_IOUT_FLAGS = 8'h7b;
    localparam logic [7:0] CODE_INPUT_FLAGS = 8'h7c;
    localparam logic [7:0] CODE_THERMAL_FLAGS = 8'h7d;
    localparam logic [7:0] CODE_COMMS_FLAGS = 8'h7e;
    localparam logic [7:0] CODE_VIN_READ = 8'h88;
    localparam logic [7:0] CODE_VOUT_READ = 8'h8b;
    localparam logic [7:0] CODE_IOUT_READ = 8'h8c;
    localparam logic [7:0] CODE_TEMP_READ = 8'h8d;
    localparam logic [7:0] CODE_KIND_WORD = 8'hd0;
    localparam logic [7:0] CODE_VOUT_GAIN = 8'hd1;
    localparam logic [7:0] CODE_VOUT_OFFSET = 8'hd2;
    localparam logic [7:0] CODE_VIN_GAIN = 8'hd3;
    localparam logic [7:0] CODE_VIN_OFFSET = 8'hd4;

    // Flag bit positions.
    localparam int OVERCURRENT_FAULT_BIT = 7;
    localparam int OVERCURRENT_WARNING_BIT = 5;
    localparam int POWER_LIMIT_BIT = 2;
    localparam int INPUT_OVERVOLTAGE_FAULT_BIT = 7;
    localparam int INPUT_UNDERVOLTAGE_FAULT_BIT = 4;
    localparam int LOW_INPUT_OFF_BIT = 3;
    localparam int OVERHEAT_FAULT_BIT = 7;
    localparam int OVERHEAT_WARNING_BIT = 6;
    localparam int BAD_COMMAND_BIT = 7;
    localparam int BAD_DATA_BIT = 6;
    localparam int PACKET_CHECK_ERROR_BIT = 5;

    // Bits that exist in each flag byte; all others read as zero.
    localparam int FLAG_BYTES = 4;
    localparam logic [7:0] FLAG_MASKS [FLAG_BYTES] = '{8'ha4, 8'h98, 8'hc0, 8'he0};

    // Kind word layout.
    localparam int WRITE_PROTECT_BIT = 1;
    localparam int NAME_LSB = 2;
    localparam int NAME_MSB = 7;
    localparam int NAME_W = 6;
    localparam logic WRITE_PROTECT_RESET = 1'b1;

    // Calibration limits and defaults.
    localparam logic [15:0] GAIN_RESET = 16'h2000;
    localparam logic [15:0] GAIN_MIN = 16'h1999;
    localparam logic [15:0] GAIN_MAX = 16'h2666;
    localparam int EXP_LSB = 11;
    localparam int EXP_MSB = 15;
    localparam logic [4:0] VOUT_OFFSET_EXP = 5'h14;
    localparam logic [4:0] VIN_OFFSET_EXP = 5'h1d;
    localparam logic [15:0] VOUT_OFFSET_RESET = 16'ha000;
    localparam logic [15:0] VIN_OFFSET_RESET = 16'he800;

    // Order of the flag bytes in the flag array.
    typedef enum logic [1:0] {
        FLAG_IOUT = 2'h0,
        FLAG_INPUT = 2'h1,
        FLAG_THERMAL = 2'h2,
        FLAG_COMMS = 2'h3
    } pmbst_flag_sel_type;
endpackage

// File: rtl/pmbst_flag_if.sv
// Set, clear and value signals of one sticky flag byte.
`timescale 1ns/1ps
interface pmbst_flag_if;
    logic [7:0] set;
    logic [7:0] clr;
    logic [7:0] value;
    modport owner (input set, input clr, output value);
    modport user (output set, output clr, input value);
endinterface

// File: rtl/pmbst_flag_byte.sv
// One sticky status byte with write-one-to-clear and fixed-zero unsupported bits.
`timescale 1ns/1ps
module pmbst_flag_byte #(
    parameter logic [7:0] SUPPORTED = 8'hff
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Flag access
    pmbst_flag_if.owner flags
);
    logic [7:0] flag_reg;
    logic [7:0] flag_next;

    // A new event in the clearing cycle survives, so no fault is lost.
    always_comb begin
        flag_next = ((flag_reg & ~flags.clr) | flags.set) & SUPPORTED;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_reg <= 8'h00;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flags.value = flag_reg;
endmodule // pmbst_flag_byte

// File: rtl/pmbst_regs.sv
// Status, telemetry and calibration register bank behind the command port.
`timescale 1ns/1ps
module pmbst_regs #(
    // Module designation; the default value is arbitrary.
    parameter logic [pmbst_pkg::NAME_W-1:0] MODULE_NAME = 6'h15,
    parameter logic [15:0] VOUT_GAIN_INIT = pmbst_pkg::GAIN_RESET,
    parameter logic [15:0] VIN_GAIN_INIT = pmbst_pkg::GAIN_RESET,
    parameter logic [15:0] VOUT_OFFSET_INIT = pmbst_pkg::VOUT_OFFSET_RESET,
    parameter logic [15:0] VIN_OFFSET_INIT = pmbst_pkg::VIN_OFFSET_RESET
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Command port from the bus transaction layer
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    // Link error reported by the transaction layer
    input wire logic packet_check_error,
    // Fault events from the converter monitor
    input wire logic overcurrent_fault,
    input wire logic overcurrent_warning,
    input wire logic power_limiting,
    input wire logic input_overvoltage_fault,
    input wire logic input_undervoltage_fault,
    input wire logic low_input_off,
    input wire logic overheat_fault,
    input wire logic overheat_warning,
    // Telemetry from the converter monitor
    input wire logic [15:0] input_voltage_value,
    input wire logic [15:0] output_voltage_value,
    input wire logic [15:0] output_current_value,
    input wire logic [15:0] temperature_value,
    // Settings for the readback scaling, write protection and module name
    output logic [15:0] vout_sense_gain,
    output logic [15:0] vout_sense_offset,
    output logic [15:0] vin_sense_gain,
    output logic [15:0] vin_sense_offset,
    output logic write_protect_enable,
    output logic [pmbst_pkg::NAME_W-1:0] module_name
);
    // Decoding and range checks.
    function automatic logic gain_ok(input logic [15:0] value);
        gain_ok = (value >= pmbst_pkg::GAIN_MIN) && (value <= pmbst_pkg::GAIN_MAX);
    endfunction

    function automatic logic exp_ok(input logic [15:0] value, input logic [4:0] exponent);
        exp_ok = value[pmbst_pkg::EXP_MSB:pmbst_pkg::EXP_LSB] == exponent;
    endfunction

    function automatic logic is_telemetry(input logic [7:0] code);
        is_telemetry = (code == pmbst_pkg::CODE_VIN_READ)
            || (code == pmbst_pkg::CODE_VOUT_READ)
            || (code == pmbst_pkg::CODE_IOUT_READ)
            || (code == pmbst_pkg::CODE_TEMP_READ);
    endfunction

    function automatic logic is_flag(input logic [7:0] code);
        is_flag = (code >= pmbst_pkg::CODE_IOUT_FLAGS)
            && (code <= pmbst_pkg::CODE_COMMS_FLAGS);
    endfunction

    function automatic logic is_cal(input logic [7:0] code);
        is_cal = (code >= pmbst_pkg::CODE_VOUT_GAIN)
            && (code <= pmbst_pkg::CODE_VIN_OFFSET);
    endfunction

    function automatic logic is_known(input logic [7:0] code);
        is_known = is_flag(code) || is_telemetry(code) || is_cal(code)
            || (code == pmbst_pkg::CODE_KIND_WORD);
    endfunction

    // Parameter checks.
    if (!gain_ok(VOUT_GAIN_INIT) || !gain_ok(VIN_GAIN_INIT)) begin : g_gain_check
        $error("Gain reset value lies outside the accepted range.");
    end
    if (!exp_ok(VOUT_OFFSET_INIT, pmbst_pkg::VOUT_OFFSET_EXP)
        || !exp_ok(VIN_OFFSET_INIT, pmbst_pkg::VIN_OFFSET_EXP)) begin : g_offset_check
        $error("Offset reset value carries the wrong exponent.");
    end

    // Registers.
    logic wp_reg;
    logic [pmbst_pkg::NAME_W-1:0] name_reg;
    logic [15:0] vout_gain_reg;
    logic [15:0] vout_offset_reg;
    logic [15:0] vin_gain_reg;
    logic [15:0] vin_offset_reg;
    logic rsp_valid_reg;
    logic [15:0] rsp_data_reg;
    logic [15:0] read_next;

    // Command qualifiers.
    logic wr;
    logic cal_wr;
    logic cal_value_ok;
    logic bad_command;
    logic bad_data;

    assign wr = cmd_valid && cmd_write;
    assign cal_wr = wr && is_cal(cmd_code) && !wp_reg;

    always_comb begin
        case (cmd_code)
            pmbst_pkg::CODE_VOUT_GAIN: cal_value_ok = gain_ok(cmd_wdata);
            pmbst_pkg::CODE_VIN_GAIN: cal_value_ok = gain_ok(cmd_wdata);
            pmbst_pkg::CODE_VOUT_OFFSET: begin
                cal_value_ok = exp_ok(cmd_wdata, pmbst_pkg::VOUT_OFFSET_EXP);
            end
            pmbst_pkg::CODE_VIN_OFFSET: begin
                cal_value_ok = exp_ok(cmd_wdata, pmbst_pkg::VIN_OFFSET_EXP);
            end
            default: cal_value_ok = 1'b0;
        endcase
    end

    // A rejected value and a write to a read-only reading both count as bad data.
    // A write dropped by protection is not flagged, so a locked part stays quiet.
    assign bad_command = cmd_valid && !is_known(cmd_code);
    assign bad_data = (wr && is_telemetry(cmd_code)) || (cal_wr && !cal_value_ok);

    // Flag bytes.
    pmbst_flag_if flag_bus [pmbst_pkg::FLAG_BYTES] ();

    always_comb begin
        flag_bus[pmbst_pkg::FLAG_IOUT].set = 8'h00;
        flag_bus[pmbst_pkg::FLAG_IOUT].set[pmbst_pkg::OVERCURRENT_FAULT_BIT] =
            overcurrent_fault;
        flag_bus[pmbst_pkg::FLAG_IOUT].set[pmbst_pkg::OVERCURRENT_WARNING_BIT] =
            overcurrent_warning;
        flag_bus[pmbst_pkg::FLAG_IOUT].set[pmbst_pkg::POWER_LIMIT_BIT] =
            power_limiting;
    end

    always_comb begin
        flag_bus[pmbst_pkg::FLAG_INPUT].set = 8'h00;
        flag_bus[pmbst_pkg::FLAG_INPUT].set[pmbst_pkg::INPUT_OVERVOLTAGE_FAULT_BIT] =
            input_overvoltage_fault;
        flag_bus[pmbst_pkg::FLAG_INPUT].set[pmbst_pkg::INPUT_UNDERVOLTAGE_FAULT_BIT] =
            input_undervoltage_fault;
        flag_bus[pmbst_pkg::FLAG_INPUT].set[pmbst_pkg::LOW_INPUT_OFF_BIT] =
            low_input_off;
    end

    always_comb begin
        flag_bus[pmbst_pkg::FLAG_THERMAL].set = 8'h00;
        flag_bus[pmbst_pkg::FLAG_THERMAL].set[pmbst_pkg::OVERHEAT_FAULT_BIT] =
            overheat_fault;
        flag_bus[pmbst_pkg::FLAG_THERMAL].set[pmbst_pkg::OVERHEAT_WARNING_BIT] =
            overheat_warning;
    end

    always_comb begin
        flag_bus[pmbst_pkg::FLAG_COMMS].set = 8'h00;
        flag_bus[pmbst_pkg::FLAG_COMMS].set[pmbst_pkg::BAD_COMMAND_BIT] = bad_command;
        flag_bus[pmbst_pkg::FLAG_COMMS].set[pmbst_pkg::BAD_DATA_BIT] = bad_data;
        flag_bus[pmbst_pkg::FLAG_COMMS].set[pmbst_pkg::PACKET_CHECK_ERROR_BIT] =
            packet_check_error;
    end

    for (genvar i = 0; i < pmbst_pkg::FLAG_BYTES; i++) begin : g_flags
        // Writing a one to a flag bit clears it.
        assign flag_bus[i].clr = (wr && (cmd_code == pmbst_pkg::CODE_IOUT_FLAGS + 8'(i)))
            ? cmd_wdata[7:0] : 8'h00;

        pmbst_flag_byte #(
            .SUPPORTED(pmbst_pkg::FLAG_MASKS[i])
        ) u_flag (
            .clk(clk),
            .rst_b(rst_b),
            .flags(flag_bus[i])
        );
    end

    // Kind word. Protection itself stays writable, otherwise a locked part
    // could never be unlocked again.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_reg <= pmbst_pkg::WRITE_PROTECT_RESET;
        end else if (wr && (cmd_code == pmbst_pkg::CODE_KIND_WORD)) begin
            wp_reg <= cmd_wdata[pmbst_pkg::WRITE_PROTECT_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            name_reg <= MODULE_NAME;
        end else if (wr && (cmd_code == pmbst_pkg::CODE_KIND_WORD) && !wp_reg) begin
            name_reg <= cmd_wdata[pmbst_pkg::NAME_MSB:pmbst_pkg::NAME_LSB];
        end
    end

    // Calibration. Only the working copy lives here; the nonvolatile store
    // is loaded through the reset values and is handled elsewhere.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vout_gain_reg <= VOUT_GAIN_INIT;
        end else if (cal_wr && cal_value_ok && (cmd_code == pmbst_pkg::CODE_VOUT_GAIN)) begin
            vout_gain_reg <= cmd_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vout_offset_reg <= VOUT_OFFSET_INIT;
        end else if (cal_wr && cal_value_ok
                     && (cmd_code == pmbst_pkg::CODE_VOUT_OFFSET)) begin
            vout_offset_reg <= cmd_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vin_gain_reg <= VIN_GAIN_INIT;
        end else if (cal_wr && cal_value_ok && (cmd_code == pmbst_pkg::CODE_VIN_GAIN)) begin
            vin_gain_reg <= cmd_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vin_offset_reg <= VIN_OFFSET_INIT;
        end else if (cal_wr && cal_value_ok
                     && (cmd_code == pmbst_pkg::CODE_VIN_OFFSET)) begin
            vin_offset_reg <= cmd_wdata;
        end
    end

    // Read selection. Unknown codes and writes answer with zero.
    always_comb begin
        read_next = 16'h0000;
        case (cmd_code)
            pmbst_pkg::CODE_IOUT_FLAGS: begin
                read_next[7:0] = flag_bus[pmbst_pkg::FLAG_IOUT].value;
            end
            pmbst_pkg::CODE_INPUT_FLAGS: begin
                read_next[7:0] = flag_bus[pmbst_pkg::FLAG_INPUT].value;
            end
            pmbst_pkg::CODE_THERMAL_FLAGS: begin
                read_next[7:0] = flag_bus[pmbst_pkg::FLAG_THERMAL].value;
            end
            pmbst_pkg::CODE_COMMS_FLAGS: begin
                read_next[7:0] = flag_bus[pmbst_pkg::FLAG_COMMS].value;
            end
            pmbst_pkg::CODE_VIN_READ: read_next = input_voltage_value;
            pmbst_pkg::CODE_VOUT_READ: read_next = output_voltage_value;
            pmbst_pkg::CODE_IOUT_READ: read_next = output_current_value;
            pmbst_pkg::CODE_TEMP_READ: read_next = temperature_value;
            pmbst_pkg::CODE_KIND_WORD: begin
                read_next[pmbst_pkg::NAME_MSB:pmbst_pkg::NAME_LSB] = name_reg;
                read_next[pmbst_pkg::WRITE_PROTECT_BIT] = wp_reg;
            end
            pmbst_pkg::CODE_VOUT_GAIN: read_next = vout_gain_reg;
            pmbst_pkg::CODE_VOUT_OFFSET: read_next = vout_offset_reg;
            pmbst_pkg::CODE_VIN_GAIN: read_next = vin_gain_reg;
            pmbst_pkg::CODE_VIN_OFFSET: read_next = vin_offset_reg;
            default: read_next = 16'h0000;
        endcase
    end

    // Answer one cycle after every command.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= cmd_valid;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_data_reg <= 16'h0000;
        end else if (cmd_valid) begin
            rsp_data_reg <= cmd_write ? 16'h0000 : read_next;
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rsp_data_reg;
    assign vout_sense_gain = vout_gain_reg;
    assign vout_sense_offset = vout_offset_reg;
    assign vin_sense_gain = vin_gain_reg;
    assign vin_sense_offset = vin_offset_reg;
    assign write_protect_enable = wp_reg;
    assign module_name = name_reg;
endmodule // pmbst_regs

// File: verification/pmbst_regs_assertions.sv
// Checker on the command port and settings outputs of the register bank.
`timescale 1ns/1ps
module pmbst_regs_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    // Telemetry and settings
    input wire logic [15:0] input_voltage_value,
    input wire logic [15:0] vout_sense_gain,
    input wire logic [15:0] vout_sense_offset,
    input wire logic [15:0] vin_sense_gain,
    input wire logic [15:0] vin_sense_offset,
    input wire logic write_protect_enable,
    input wire logic [pmbst_pkg::NAME_W-1:0] module_name
);
    logic [15:0] wdata_q;
    logic rd, wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    assign rd = cmd_valid && !cmd_write;
    assign wr = cmd_valid && cmd_write;
    // Last cycle's write data, so a stored value can be tied to what was sent.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) wdata_q <= 16'h0000;
        else wdata_q <= cmd_wdata;
    end
    a_answer_next: assert property (rsp_valid == $past(cmd_valid))
        else $error("answer strobe misplaced");
    a_telemetry_read: assert property (rd && cmd_code == 8'h88 |=>
        rsp_data == $past(input_voltage_value)) else $error("telemetry read wrong");
    a_kind_read: assert property (rd && cmd_code == 8'hd0 |=>
        rsp_data == {8'h00, module_name, write_protect_enable, 1'b0})
        else $error("kind word wrong");
    a_flag_unused: assert property (rd && cmd_code == 8'h7b |=>
        (rsp_data & 16'hff5b) == 16'h0000) else $error("unsupported flag bit set");
    a_unknown_zero: assert property (rd && !(cmd_code inside {[8'h7b:8'h7e], 8'h88,
        [8'h8b:8'h8d], [8'hd0:8'hd4]}) |=> rsp_data == 16'h0000) else $error("unknown read");
    a_gain_bounds: assert property (vout_sense_gain inside {[16'h1999:16'h2666]} &&
        vin_sense_gain inside {[16'h1999:16'h2666]}) else $error("gain out of range");
    a_offset_exp: assert property (vout_sense_offset[15:11] == 5'h14 &&
        vin_sense_offset[15:11] == 5'h1d) else $error("offset exponent wrong");
    a_protect_hold: assert property (wr && write_protect_enable && cmd_code > 8'hd0 &&
        cmd_code < 8'hd5 |=> $stable(vout_sense_gain) && $stable(vin_sense_gain) &&
        $stable(vout_sense_offset) && $stable(vin_sense_offset)) else $error("protected write");
    a_protect_bit: assert property (wr && cmd_code == 8'hd0 |=>
        write_protect_enable == wdata_q[1]) else $error("protect bit not taken");
    a_gain_store: assert property (wr && !write_protect_enable && cmd_code == 8'hd1 &&
        cmd_wdata inside {[16'h1999:16'h2666]} |=> vout_sense_gain == wdata_q)
        else $error("gain not stored");
endmodule // pmbst_regs_chk
bind pmbst_regs pmbst_regs_chk u_chk (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .input_voltage_value(input_voltage_value),
    .vout_sense_gain(vout_sense_gain), .vout_sense_offset(vout_sense_offset),
    .vin_sense_gain(vin_sense_gain), .vin_sense_offset(vin_sense_offset),
    .write_protect_enable(write_protect_enable), .module_name(module_name));

// File: verification/pmbst_host_model.sv
// Behavioural host that issues commands on the register bank's command port.
`timescale 1ns/1ps
module pmbst_host_model (
    // Clock
    input wire logic clk,
    // Command port
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // Entered just after an edge; the strobe stays up so commands may run back to back.
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
        output logic ok, output logic [15:0] rd);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = c;
        cmd_wdata = d;
        @(posedge clk);
        #1;
        ok = rsp_valid;
        rd = rsp_data;
    endtask
    // Released lines show the inverse of the last value, never a stale copy.
    task automatic rest();
        cmd_valid = 1'b0;
        cmd_write = ~cmd_write;
        cmd_code = ~cmd_code;
        cmd_wdata = ~cmd_wdata;
        @(posedge clk);
        #1;
    endtask
endmodule // pmbst_host_model

// File: verification/tb_top.sv
// Self-checking bench for the status, telemetry and calibration register bank.
`timescale 1ns/1ps
module tb_top;
    // Module designation handed to the design; the value is arbitrary.
    localparam logic [5:0] NAME = 6'h2a;
    logic clk, rst_b, cmd_valid, cmd_write, rsp_valid, pce, wp_out, m_wp;
    logic [7:0] cmd_code, ev;
    logic [15:0] cmd_wdata, rsp_data, go, oo, gi, oi, m_go, m_oo, m_gi, m_oi;
    logic [5:0] name_out, m_name;
    logic [15:0] tel [4];
    logic [7:0] flg [4];
    logic [7:0] codes [14] = '{8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h88, 8'h8b, 8'h8c, 8'h8d,
        8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'h89};
    logic [15:0] edges [4] = '{16'h1998, 16'h1999, 16'h2666, 16'h2667};
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    pmbst_regs #(.MODULE_NAME(NAME)) dut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .packet_check_error(pce),
        .overcurrent_fault(ev[0]), .overcurrent_warning(ev[1]), .power_limiting(ev[2]),
        .input_overvoltage_fault(ev[3]), .input_undervoltage_fault(ev[4]),
        .low_input_off(ev[5]), .overheat_fault(ev[6]), .overheat_warning(ev[7]),
        .input_voltage_value(tel[0]), .output_voltage_value(tel[1]),
        .output_current_value(tel[2]), .temperature_value(tel[3]), .vout_sense_gain(go),
        .vout_sense_offset(oo), .vin_sense_gain(gi), .vin_sense_offset(oi),
        .write_protect_enable(wp_out), .module_name(name_out));
    pmbst_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            test_done();
        end
    end
    task automatic test_done();
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] expect_read(input logic [7:0] c);
        case (c)
            8'h7b, 8'h7c, 8'h7d, 8'h7e: return {8'h00, flg[c - 8'h7b]};
            8'h88: return tel[0];
            8'h8b: return tel[1];
            8'h8c: return tel[2];
            8'h8d: return tel[3];
            8'hd0: return {8'h00, m_name, m_wp, 1'b0};
            8'hd1: return m_go;
            8'hd2: return m_oo;
            8'hd3: return m_gi;
            8'hd4: return m_oi;
            default: return 16'h0000;
        endcase
    endfunction
    task automatic store(input logic ok, input logic [15:0] d, inout logic [15:0] r);
        if (ok) r = d;
        else flg[3][6] = 1'b1;
    endtask
    // One idle cycle carrying monitor events; the model sets the matching sticky flags.
    task automatic idle(input logic [7:0] e, input logic p);
        ev = e;
        pce = p;
        foreach (tel[k]) tel[k] = 16'($urandom);
        host.rest();
        flg[0] |= {e[0], 1'b0, e[1], 2'b00, e[2], 2'b00};
        flg[1] |= {e[3], 2'b00, e[4], e[5], 3'b000};
        flg[2] |= {e[6], e[7], 6'h00};
        flg[3] |= {2'b00, p, 5'h00};
    endtask
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
        logic ok;
        logic [15:0] rd, exp;
        logic [7:0] was;
        ev = 8'h00;
        pce = 1'b0;
        was = flg[3];
        exp = w ? 16'h0000 : expect_read(c);
        host.xfer(w, c, d, ok, rd);
        check({15'h0000, ok}, 16'h0001);
        check(rd, exp);
        if (!(c inside {[8'h7b:8'h7e], 8'h88, [8'h8b:8'h8d], [8'hd0:8'hd4]})) flg[3][7] = 1'b1;
        else if (w) begin
            case (c)
                8'h7b, 8'h7c, 8'h7d, 8'h7e: flg[c - 8'h7b] &= ~d[7:0];
                8'h88, 8'h8b, 8'h8c, 8'h8d: flg[3][6] = 1'b1;
                8'hd0: begin
                    if (!m_wp) m_name = d[7:2];
                    m_wp = d[1];
                end
                8'hd1: if (!m_wp) store(d inside {[16'h1999:16'h2666]}, d, m_go);
                8'hd2: if (!m_wp) store(d[15:11] == 5'h14, d, m_oo);
                8'hd3: if (!m_wp) store(d inside {[16'h1999:16'h2666]}, d, m_gi);
                8'hd4: if (!m_wp) store(d[15:11] == 5'h1d, d, m_oi);
                default: ;
            endcase
        end
        check(go, m_go);
        check(oo, m_oo);
        check(gi, m_gi);
        check(oi, m_oi);
        check({9'h000, name_out, wp_out}, {9'h000, m_name, m_wp});
        // A comms flag raised by this command is only read back after a quiet cycle.
        if (flg[3] !== was) host.rest();
    endtask
    initial begin
        logic [31:0] r;
        logic [15:0] d;
        logic ok_q;
        ev = 8'h00;
        pce = 1'b0;
        tel = '{default: 16'h0000};
        flg = '{default: 8'h00};
        rst_b = 1'b0;
        m_go = pmbst_pkg::GAIN_RESET;
        m_gi = pmbst_pkg::GAIN_RESET;
        m_oo = pmbst_pkg::VOUT_OFFSET_RESET;
        m_oi = pmbst_pkg::VIN_OFFSET_RESET;
        m_wp = pmbst_pkg::WRITE_PROTECT_RESET;
        m_name = NAME;
        void'($urandom(16531));
        repeat (3) @(posedge clk);
        #1;
        rst_b = 1'b1;
        foreach (codes[i]) cmd(1'b0, codes[i], 16'h0000);
        cmd(1'b1, 8'hd1, 16'h2100);
        cmd(1'b1, 8'hd0, 16'h00fc);
        foreach (edges[i]) begin
            cmd(1'b1, 8'hd1, edges[i]);
            cmd(1'b1, 8'hd3, edges[i]);
            cmd(1'b0, 8'h7e, 16'h0000);
            cmd(1'b1, 8'h7e, 16'h00ff);
        end
        idle(8'hff, 1'b1);
        for (int i = 0; i < 4; i++) begin
            cmd(1'b0, codes[i], 16'h0000);
            cmd(1'b1, codes[i], 16'h00ff);
        end
        // A fault that arrives in the clearing cycle must survive the clear.
        ev = 8'h01;
        host.xfer(1'b1, 8'h7b, 16'h0080, ok_q, d);
        flg[0][7] = 1'b1;
        cmd(1'b0, 8'h7b, 16'h0000);
        repeat (400) begin
            r = $urandom;
            case (r[12:10])
                3'h0: d = 16'h1999 + 16'($urandom % 3278);
                3'h1: d = {5'h14, 11'($urandom)};
                3'h2: d = {5'h1d, 11'($urandom)};
                3'h3: d = 16'h0000;
                default: d = 16'($urandom);
            endcase
            if (r[8]) idle(8'($urandom & $urandom & $urandom), r[15:13] == 3'h0);
            cmd(r[9], codes[r[7:4] % 14], d);
        end
        test_done();
    end
endmodule // tb_top
